/* logic/mipr_pkg.sv */
// mipr_pkg.sv - constants and types shared by the maskable interrupt priority block
package mipr_pkg;

   // ------------------------------------------------------------------
   // line counts and vectors
   // ------------------------------------------------------------------
   localparam int NUM_LINES = 48;
   localparam int IDX_W = 6;
   localparam logic [7:0] VECTOR_BASE = 8'h10;
   localparam logic [7:0] VECTOR_MAX = 8'h3f;
   localparam logic [47:0] RESERVED_LINES = 48'h0000_0020_4015; // lines 0,2,4,14,21

   // ------------------------------------------------------------------
   // named source lines
   // ------------------------------------------------------------------
   localparam int LINE_RANDOM = 3;
   localparam int LINE_TIMER_4TH = 25;
   localparam int LINE_TIMER_1ST = 28;
   localparam int LINE_AUDIO = 34;

   // ------------------------------------------------------------------
   // register map (word addresses on the plain port)
   // ------------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_VECTOR = 4'h0;
   localparam logic [3:0] ADDR_NMI_STATUS = 4'h1;
   localparam logic [3:0] ADDR_STATUS_LOW = 4'h5;
   localparam logic [3:0] ADDR_STATUS_MID = 4'h6;
   localparam logic [3:0] ADDR_STATUS_HIGH = 4'h8;
   localparam logic [3:0] ADDR_ENABLE_LOW = 4'h7;
   localparam logic [3:0] ADDR_ENABLE_MID = 4'h9;
   localparam logic [3:0] ADDR_ENABLE_HIGH = 4'ha;
   localparam logic [3:0] ADDR_EVT_STATUS = 4'hb;
   localparam logic [3:0] ADDR_EVT_CLEAR = 4'hc;
   localparam logic [3:0] ADDR_EVT_ENABLE = 4'hd;
   localparam logic [15:0] ENABLE_RESET = 16'hffff;

   // event bits: 0 maskable taken, 1 non-maskable taken, 2 spurious acknowledge
   localparam int EVT_W = 3;

   // ------------------------------------------------------------------
   // nesting state
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MIPR_IDLE = 3'b001,
      MIPR_IN_HANDLER = 3'b010,
      MIPR_NESTING = 3'b100
   } mipr_state_t;

endpackage : mipr_pkg

/* logic/mipr_priority_encoder.sv */
// mipr_priority_encoder.sv - fixed linear priority picker, top line wins
module mipr_priority_encoder #(
   parameter int LINES = 48,
   parameter int IDX_W = 6
) (
   input wire logic [LINES-1:0] active_in,
   output logic any_out,
   output logic [IDX_W-1:0] index_out
);
   // ------------------------------------------------------------------
   // scan upward so that the highest line is the last to win
   // ------------------------------------------------------------------
   always_comb begin
      any_out = 1'b0;
      index_out = '0;
      for (int i = 0; i < LINES; i++) begin
         if (active_in[i]) begin
            any_out = 1'b1; // RL16
            index_out = IDX_W'(i); // RL1
         end
      end
   end
endmodule : mipr_priority_encoder

/* logic/mipr_top.sv */
// mipr_top.sv - maskable interrupt arbitration and nesting control
//
// Summary of operation
// RL1 - highest enabled pending line wins; line 47 ranks top, lower numbers rank below
// RL2 - audio interface request drives line 34
// RL3 - random number source request drives line 3
// RL4 - four versatile timer requests drive lines 28 down to 25 in order
// RL5 - software points reserved line vectors at a default error handler
// RL6 - non-maskable requests always preempt, even another non-maskable handler
// RL7 - after a maskable take, no further maskable until nesting permitted
// RL8 - nested maskable accepted only once status word enable flag is set
// RL9 - handler sets that flag with the load processor register instruction
// RL10 - software clears non-nesting sources' enables before setting the flag
// RL11 - disabled source leaves arbitration but stays visible in status
// RL12 - no hardware limit on nesting depth
// RL13 - vector is 10h plus winning line number, range 10h to 3Fh
// RL14 - status bits show raw requests whatever the enables say
// RL15 - all enable words reset to all ones; the event enable word resets to zero instead
// RL16 - reserved lines tied low; no request raised when nothing wins
module mipr_top
   import mipr_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // named peripheral requests and the remaining generic lines
   input wire logic [mipr_pkg::NUM_LINES-1:0] periph_req_in,
   input wire logic audio_interface_req_in,
   input wire logic random_number_source_req_in,
   input wire logic [3:0] versatile_timer_req_in,
   input wire logic nmi_req_in,
   // core side
   input wire logic inta_in,
   input wire logic nmi_ack_in,
   input wire logic handler_exit_in,
   input wire logic status_enable_flag_in,
   output logic irq_out,
   output logic nmi_out,
   output logic [7:0] vector_out,
   // register port
   input wire logic [mipr_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   output logic int_out
);
   import mipr_pkg::*;

   // ------------------------------------------------------------------
   // request routing
   // ------------------------------------------------------------------
   logic [NUM_LINES-1:0] raw_req;
   logic [NUM_LINES-1:0] enable_q;
   logic [NUM_LINES-1:0] eligible;
   logic any_win;
   logic [IDX_W-1:0] win_idx;
   mipr_state_t state_q;
   logic [31:0] depth_q;
   logic nmi_pending_q;
   logic [EVT_W-1:0] evt_status_q;
   logic [EVT_W-1:0] evt_enable_q;
   logic [EVT_W-1:0] evt_set;
   logic accept_maskable;

   // named sources override their generic lines; reserved lines held low
   always_comb begin
      raw_req = periph_req_in;
      raw_req[LINE_AUDIO] = audio_interface_req_in; // RL2
      raw_req[LINE_RANDOM] = random_number_source_req_in; // RL3
      for (int t = 0; t < 4; t++) begin
         raw_req[LINE_TIMER_1ST - t] = versatile_timer_req_in[t]; // RL4
      end
      raw_req = raw_req & ~RESERVED_LINES; // RL16
   end

   // disabled lines drop out of arbitration only
   assign eligible = raw_req & enable_q; // RL11

   mipr_priority_encoder #(
      .LINES(NUM_LINES),
      .IDX_W(IDX_W)
   ) u_enc (
      .active_in(eligible),
      .any_out(any_win),
      .index_out(win_idx)
   );

   // ------------------------------------------------------------------
   // nesting control
   // ------------------------------------------------------------------
   // idle accepts freely; inside a handler only once the status flag is set
   always_comb begin
      case (state_q)
         // the take itself closes the gate, else the request stands one cycle too long
         MIPR_IDLE: accept_maskable = !inta_in || status_enable_flag_in; // RL7
         MIPR_IN_HANDLER: accept_maskable = status_enable_flag_in; // RL7
         MIPR_NESTING: accept_maskable = status_enable_flag_in; // RL8
         default: accept_maskable = 1'b0;
      endcase
   end

   // depth counter wraps on overflow but is wide enough never to do so in practice
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         depth_q <= 32'h0;
      end else if (inta_in && !handler_exit_in) begin
         depth_q <= depth_q + 32'h1; // RL12
      end else if (handler_exit_in && !inta_in && depth_q != 32'h0) begin
         depth_q <= depth_q - 32'h1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_q <= MIPR_IDLE;
      end else begin
         case (state_q)
            MIPR_IDLE: begin
               if (inta_in) begin
                  state_q <= MIPR_IN_HANDLER; // RL7
               end
            end
            MIPR_IN_HANDLER: begin
               if (handler_exit_in && depth_q <= 32'h1 && !inta_in) begin
                  state_q <= MIPR_IDLE;
               end else if (inta_in) begin
                  state_q <= MIPR_NESTING;
               end
            end
            MIPR_NESTING: begin
               if (handler_exit_in && depth_q == 32'h2 && !inta_in) begin
                  state_q <= MIPR_IN_HANDLER;
               end
            end
            default: state_q <= MIPR_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // outputs to the core
   // ------------------------------------------------------------------
   // vector tracks the winner; may be stale for one cycle while it updates
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         irq_out <= 1'b0;
         vector_out <= VECTOR_BASE;
      end else begin
         irq_out <= any_win && accept_maskable; // RL16
         vector_out <= VECTOR_BASE + {2'b00, win_idx}; // RL13
      end
   end

   // non-maskable has no gate: preempts any handler, including its own kind
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         nmi_pending_q <= 1'b0;
      end else if (nmi_req_in) begin
         nmi_pending_q <= 1'b1; // RL6
      end else if (nmi_ack_in) begin
         nmi_pending_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         nmi_out <= 1'b0;
      end else begin
         // drop with the acknowledge so the core does not take the same request twice
         nmi_out <= (nmi_pending_q && !nmi_ack_in) || nmi_req_in; // RL6
      end
   end

   // ------------------------------------------------------------------
   // enable words
   // ------------------------------------------------------------------
   // reserved line 0 enable is stored but unused
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         enable_q <= {ENABLE_RESET, ENABLE_RESET, ENABLE_RESET}; // RL15
      end else if (reg_wr_in) begin
         if (reg_addr_in == ADDR_ENABLE_LOW) begin
            enable_q[15:0] <= reg_wdata_in;
         end else if (reg_addr_in == ADDR_ENABLE_MID) begin
            enable_q[31:16] <= reg_wdata_in;
         end else if (reg_addr_in == ADDR_ENABLE_HIGH) begin
            enable_q[47:32] <= reg_wdata_in;
         end
      end
   end

   // ------------------------------------------------------------------
   // event interrupt: sticky status, write-one clear, enable
   // ------------------------------------------------------------------
   assign evt_set = {inta_in && !any_win, nmi_ack_in, inta_in};

   // set wins over a clear arriving in the same cycle
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         evt_status_q <= '0;
      end else if (reg_wr_in && reg_addr_in == ADDR_EVT_CLEAR) begin
         evt_status_q <= (evt_status_q & ~reg_wdata_in[EVT_W-1:0]) | evt_set;
      end else begin
         evt_status_q <= evt_status_q | evt_set;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         evt_enable_q <= '0;
      end else if (reg_wr_in && reg_addr_in == ADDR_EVT_ENABLE) begin
         evt_enable_q <= reg_wdata_in[EVT_W-1:0];
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         int_out <= 1'b0;
      end else begin
         int_out <= |(evt_status_q & evt_enable_q);
      end
   end

   // ------------------------------------------------------------------
   // read port: data stand one cycle after the strobe, zero otherwise
   // ------------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 16'h0;
      end else if (!reg_rd_in) begin
         reg_rdata_out <= 16'h0;
      end else if (reg_addr_in == ADDR_VECTOR) begin
         reg_rdata_out <= {8'h00, vector_out};
      end else if (reg_addr_in == ADDR_NMI_STATUS) begin
         reg_rdata_out <= {15'h0, nmi_pending_q};
      end else if (reg_addr_in == ADDR_STATUS_LOW) begin
         reg_rdata_out <= raw_req[15:0]; // RL14
      end else if (reg_addr_in == ADDR_STATUS_MID) begin
         reg_rdata_out <= raw_req[31:16]; // RL14
      end else if (reg_addr_in == ADDR_STATUS_HIGH) begin
         reg_rdata_out <= raw_req[47:32]; // RL14
      end else if (reg_addr_in == ADDR_ENABLE_LOW) begin
         reg_rdata_out <= enable_q[15:0];
      end else if (reg_addr_in == ADDR_ENABLE_MID) begin
         reg_rdata_out <= enable_q[31:16];
      end else if (reg_addr_in == ADDR_ENABLE_HIGH) begin
         reg_rdata_out <= enable_q[47:32];
      end else if (reg_addr_in == ADDR_EVT_STATUS) begin
         reg_rdata_out <= {13'h0, evt_status_q};
      end else if (reg_addr_in == ADDR_EVT_ENABLE) begin
         reg_rdata_out <= {13'h0, evt_enable_q};
      end else begin
         reg_rdata_out <= 16'h0;
      end
   end

endmodule : mipr_top

/* verification/mipr_core_model.sv */
// mipr_core_model.sv - behavioural processor core taking acknowledges
module mipr_core_model (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic irq_in,
   input wire logic nmi_in,
   input wire logic nest_en_in,
   input wire logic [1:0] delay_in,
   output logic inta_out = 1'b0,
   output logic nmi_ack_out = 1'b0,
   output logic handler_exit_out = 1'b0,
   output logic flag_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int depth;
   int wt;
   // one event per edge: nmi first, then a take, then a return after 3 idle cycles
   always @(posedge clock_in) begin
      inta_out <= 1'b0;
      nmi_ack_out <= 1'b0;
      handler_exit_out <= 1'b0;
      if (sys_rst_in) begin
         depth = 0;
         wt = 0;
      end else if (nmi_in && !nmi_ack_out) begin
         nmi_ack_out <= 1'b1;
      end else if (irq_in && !inta_out && wt >= delay_in) begin
         inta_out <= 1'b1;
         depth++;
         wt = 0;
      end else if (depth > 0 && wt >= 3) begin
         handler_exit_out <= 1'b1;
         depth--;
         wt = 0;
      end else begin
         wt++;
      end
      flag_out <= nest_en_in && depth > 0;
   end
endmodule : mipr_core_model

/* verification/mipr_properties.sv */
// mipr_properties.sv - port checks for the interrupt priority block
module mipr_properties
   import mipr_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [mipr_pkg::NUM_LINES-1:0] periph_req_in,
   input wire logic audio_interface_req_in,
   input wire logic random_number_source_req_in,
   input wire logic [3:0] versatile_timer_req_in,
   input wire logic nmi_req_in,
   input wire logic inta_in,
   input wire logic handler_exit_in,
   input wire logic status_enable_flag_in,
   input wire logic irq_out,
   input wire logic nmi_out,
   input wire logic [7:0] vector_out,
   input wire logic [mipr_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in
);
   logic [15:0] en_hi_q;
   logic [31:0] depth_q;
   logic any_raw;
   logic blk;
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   // shadow of the top enable word, so checks know which top lines may win
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         en_hi_q <= ENABLE_RESET;
      end else if (reg_wr_in && reg_addr_in == ADDR_ENABLE_HIGH) begin
         en_hi_q <= reg_wdata_in;
      end
   end
   // open handlers; wide counter since depth has no hardware limit
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         depth_q <= '0;
      end else begin
         depth_q <= depth_q + 32'(inta_in) - 32'(handler_exit_in);
      end
   end
   // live requests once tied-off and overridden bits are removed
   assign any_raw = |(periph_req_in & ~(RESERVED_LINES | 48'h0004_1e00_0008))
      | audio_interface_req_in | random_number_source_req_in | (|versatile_timer_req_in);
   assign blk = depth_q != 0 && !status_enable_flag_in;
   property p_top; periph_req_in[47] && en_hi_q[15] |=> vector_out == VECTOR_MAX; endproperty
   a_top: assert property (p_top) else $error("top line lost");
   property p_aud; audio_interface_req_in && en_hi_q[2]
      && !(|(periph_req_in[47:35] & en_hi_q[15:3])) |=> vector_out == 8'h32; endproperty
   a_aud: assert property (p_aud) else $error("audio vector wrong");
   property p_mask; periph_req_in[47] && !en_hi_q[15] |=> vector_out != VECTOR_MAX; endproperty
   a_mask: assert property (p_mask) else $error("masked line won");
   property p_rng; irq_out |-> vector_out > VECTOR_BASE && vector_out <= VECTOR_MAX; endproperty
   a_rng: assert property (p_rng) else $error("vector out of range");
   property p_none; !any_raw |=> !irq_out && vector_out == VECTOR_BASE; endproperty
   a_none: assert property (p_none) else $error("request with no line");
   property p_nmi; nmi_req_in |=> nmi_out; endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not raised");
   property p_once; inta_in && !status_enable_flag_in ##1 !status_enable_flag_in |-> !irq_out;
   endproperty
   a_once: assert property (p_once) else $error("second take");
   property p_gate; blk ##1 blk |-> !irq_out; endproperty
   a_gate: assert property (p_gate) else $error("nested without flag");
endmodule : mipr_properties

bind mipr_top mipr_properties chk_u (.clock_in, .sys_rst_in, .periph_req_in,
   .audio_interface_req_in, .random_number_source_req_in, .versatile_timer_req_in,
   .nmi_req_in, .inta_in, .handler_exit_in, .status_enable_flag_in, .irq_out, .nmi_out,
   .vector_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in);

/* verification/tb_top.sv */
// tb_top.sv - self-checking bench for the interrupt priority block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mipr_pkg::*;
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [47:0] periph_req_in = '0;
   logic audio_interface_req_in = 1'b0;
   logic random_number_source_req_in = 1'b0;
   logic [3:0] versatile_timer_req_in = '0;
   logic nmi_req_in = 1'b0;
   logic [3:0] reg_addr_in = '0;
   logic [15:0] reg_wdata_in = '0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic nest_en = 1'b0;
   logic [1:0] delay = '0;
   logic inta_in, nmi_ack_in, handler_exit_in, status_enable_flag_in;
   logic irq_out, nmi_out, int_out;
   logic [7:0] vector_out;
   logic [15:0] reg_rdata_out;
   logic [47:0] en;
   logic [47:0] raw;
   logic [47:0] w_live = '0;
   int n_spur = 0;
   int k2 = 0;
   int err_total = 0;
   int check_count = 0;
   int seed = 81274;
   int cyc = 0;
   int n_inta = 0;
   int n_nack = 0;
   int k0;
   int k1;
   always #10 clock_in = ~clock_in;
   mipr_top dut_u (.clock_in, .sys_rst_in, .periph_req_in, .audio_interface_req_in,
      .random_number_source_req_in, .versatile_timer_req_in, .nmi_req_in, .inta_in,
      .nmi_ack_in, .handler_exit_in, .status_enable_flag_in, .irq_out, .nmi_out, .vector_out,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .int_out);
   mipr_core_model core_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .irq_in(irq_out),
      .nmi_in(nmi_out), .nest_en_in(nest_en), .delay_in(delay), .inta_out(inta_in),
      .nmi_ack_out(nmi_ack_in), .handler_exit_out(handler_exit_in),
      .flag_out(status_enable_flag_in));
   // cycle budget and pulse counts; a hang ends in the closing report
   always @(posedge clock_in) begin
      cyc++;
      n_inta += int'(inta_in);
      n_nack += int'(nmi_ack_in);
      n_spur += int'(inta_in && w_live == '0);
      if (cyc == 8000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
      @(posedge clock_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      #1 chk(nm, e, reg_rdata_out);
   endtask : rd
   // reference: raw lines, then the top enabled line gives the vector
   task automatic drive(input logic [47:0] p, input logic [5:0] nm);
      logic [47:0] w;
      logic [15:0] ev;
      @(posedge clock_in);
      periph_req_in <= p;
      {audio_interface_req_in, random_number_source_req_in, versatile_timer_req_in} <= nm;
      raw = p;
      raw[3] = nm[4];
      raw[34] = nm[5];
      raw[28:25] = {nm[0], nm[1], nm[2], nm[3]};
      raw = raw & ~RESERVED_LINES;
      w = raw & en;
      w_live <= w;
      ev = 16'h0010;
      for (int i = 1; i < 48; i++) begin
         if (w[i]) ev = 16'(8'h10 + i);
      end
      repeat (3) @(posedge clock_in);
      #1 chk("vector", ev, 16'(vector_out));
      chk("irq_idle", 16'h0, 16'(irq_out & (ev == 16'h0010)));
   endtask : drive
   initial begin
      repeat (16) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      en = '1;
      rd(ADDR_ENABLE_LOW, ENABLE_RESET, "en_low");
      rd(ADDR_ENABLE_MID, ENABLE_RESET, "en_mid");
      rd(ADDR_ENABLE_HIGH, ENABLE_RESET, "en_high");
      rd(4'hf, 16'h0, "unmapped");
      for (int k = 0; k < 6; k++) drive('0, 6'(1 << k));
      for (int n = 0; n < 40; n++) begin
         delay <= 2'($random(seed));
         en = 48'({$random(seed), $random(seed)});
         wr(ADDR_ENABLE_LOW, en[15:0]);
         wr(ADDR_ENABLE_MID, en[31:16]);
         wr(ADDR_ENABLE_HIGH, en[47:32]);
         drive(48'({$random(seed), $random(seed)}) >> ($unsigned($random(seed)) % 48),
            6'($random(seed)));
         rd(ADDR_STATUS_LOW, raw[15:0], "status_low");
         rd(ADDR_STATUS_MID, raw[31:16], "status_mid");
         rd(ADDR_STATUS_HIGH, raw[47:32], "status_high");
      end
      en = '1;
      wr(ADDR_ENABLE_LOW, 16'hffff);
      wr(ADDR_ENABLE_MID, 16'hffff);
      wr(ADDR_ENABLE_HIGH, 16'hffff);
      drive('0, 6'h00);
      nest_en <= 1'b1;
      delay <= 2'd0;
      k0 = n_inta;
      drive(48'h4000_0000_0000, 6'h00);
      repeat (20) @(posedge clock_in);
      chk("nest_deep", 16'h1, 16'(n_inta - k0 > 4));
      nest_en <= 1'b0;
      drive('0, 6'h00);
      repeat (80) @(posedge clock_in);
      wr(ADDR_EVT_CLEAR, 16'h0007);
      k2 = n_spur;
      k1 = n_nack;
      drive(48'h4000_0000_0000, 6'h00);
      rd(ADDR_VECTOR, 16'h003e, "vec_reg");
      repeat (2) begin
         @(posedge clock_in);
         nmi_req_in <= 1'b1;
         @(posedge clock_in);
         nmi_req_in <= 1'b0;
         repeat (6) @(posedge clock_in);
      end
      chk("nmi_takes", 16'd2, 16'(n_nack - k1));
      drive('0, 6'h00);
      repeat (40) @(posedge clock_in);
      rd(ADDR_NMI_STATUS, 16'h0000, "nmi_idle");
      rd(ADDR_EVT_STATUS, 16'h0003 | ((n_spur != k2) ? 16'h0004 : 16'h0000), "evt_status");
      chk("int_masked", 16'h0, 16'(int_out));
      wr(ADDR_EVT_ENABLE, 16'h0002);
      repeat (2) @(posedge clock_in);
      #1 chk("int_on", 16'h1, 16'(int_out));
      wr(ADDR_EVT_CLEAR, 16'h0002);
      repeat (2) @(posedge clock_in);
      #1 chk("int_off", 16'h0, 16'(int_out));
      rd(ADDR_EVT_STATUS, 16'h0001 | ((n_spur != k2) ? 16'h0004 : 16'h0000), "evt_left");
      give_verdict();
   end
endmodule : tb_top
